// ===== pkg/lp_serial_regs.vh
// register map, field positions and timing constants of the low-power serial port
`ifndef LP_SERIAL_REGS_VH
`define LP_SERIAL_REGS_VH
`define OFS_CTRL 4'h0
`define OFS_BAUD 4'h1
`define OFS_STATUS 4'h2
`define OFS_TXDATA 4'h3
`define OFS_RXDATA 4'h4
`define OFS_IRQ_STAT 4'h5
`define OFS_IRQ_EN 4'h6
`define OFS_IRQ_CLR 4'h7
`define OFS_MATCH 4'h8
`define OFS_CLKSEL 4'h9
`define CTRL_EN 0
`define CTRL_TXEN 1
`define CTRL_RXEN 2
`define CTRL_HDSEL 3
`define CTRL_CTSE 4
`define CTRL_RTSE 5
`define CTRL_MUTE 6
`define CTRL_STOP 7
`define CTRL_WUS_LO 8
`define CTRL_WUS_HI 9
`define CTRL_DMAT 10
`define CTRL_DMAR 11
`define WUS_START 2'h0
`define WUS_FRAME 2'h1
`define WUS_MATCH 2'h2
`define IRQ_RXNE 0
`define IRQ_TXE 1
`define IRQ_TC 2
`define IRQ_WAKE 3
`define IRQ_ORE 4
`define IRQ_FE 5
`define IRQ_CTSI 6
`define IRQ_W 7
`define CLK_SLOW 2'h0
`define CLK_RC16 2'h1
`define CLK_SYS 2'h2
`define CLK_PBUS 2'h3
`define BAUD_RST 16'h0D05
`define WAKE_BAUD_MAX 46000
`define SLOW_BAUD_MAX 9600
`define SLOW_CLK_HZ 32768
`endif

// ===== rtl/low_power_serial_port.v
// low-power serial port with wake from stop, flow control, mute addressing and dma requests
`timescale 1ns/100ps
`include "lp_serial_regs.vh"
module low_power_serial_port (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire tick_slow_crystal_clock,
    input wire tick_internal_fast_rc_clock,
    input wire tick_system_clock,
    input wire tick_peripheral_bus_clock,
    input wire stop_mode,
    output wire osc_request,
    input wire rx_in,
    output wire tx_out,
    output wire tx_oe_n,
    input wire cts_n,
    output wire rts_n,
    output wire dma_tx_req,
    output wire dma_rx_req,
    input wire dma_tx_ack,
    input wire dma_rx_ack,
    output wire wakeup,
    output wire irq
);
    localparam ST_IDLE = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_DATA = 2'd2;
    localparam ST_STOP = 2'd3;

    reg [11:0] ctrl_ff;
    reg [15:0] baud_ff;
    reg [7:0] match_ff;
    reg [1:0] clksel_ff;
    reg [7:0] irq_en_ff;
    reg [7:0] irq_stat_ff;
    reg [7:0] nxt_irq_stat;
    reg [7:0] txbuf_ff;
    reg txfull_ff;
    reg [7:0] rxbuf_ff;
    reg rxfull_ff;
    reg muted_ff;
    reg ack_ff;
    reg [1:0] tst_ff;
    reg [15:0] tcnt_ff;
    reg [2:0] tbit_ff;
    reg [7:0] tsh_ff;
    reg txd_ff;
    reg [1:0] rst_ff;
    reg [15:0] rcnt_ff;
    reg [2:0] rbit_ff;
    reg [7:0] rsh_ff;
    reg rx_prev_ff;
    reg kick_ff;

    wire en = ctrl_ff[`CTRL_EN];
    wire hdsel = ctrl_ff[`CTRL_HDSEL];
    wire [1:0] wus = ctrl_ff[`CTRL_WUS_HI:`CTRL_WUS_LO];
    reg ktick;
    wire rx_line = hdsel ? (tst_ff == ST_IDLE ? rx_in : 1'b1) : rx_in;
    wire access = avs_read | avs_write;

    function hit;
        input [3:0] ofs;
        hit = avs_write && avs_address == ofs;
    endfunction

    // kernel clock selector, each source arrives as a one-cycle enable
    always @* begin
        case (clksel_ff)
            `CLK_SLOW: ktick = tick_slow_crystal_clock;
            `CLK_RC16: ktick = tick_internal_fast_rc_clock;
            `CLK_SYS: ktick = tick_system_clock;
            default: ktick = tick_peripheral_bus_clock;
        endcase
    end

    // the rc oscillator is only asked for while this port uses it and has work or has its receiver enabled
    assign osc_request = en && clksel_ff == `CLK_RC16 &&
        (txfull_ff || tst_ff != ST_IDLE || rst_ff != ST_IDLE || ctrl_ff[`CTRL_RXEN]);

    // one wait state so reads come from flip-flops
    assign avs_waitrequest = access & ~ack_ff;

    always @(posedge clk) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= access & ~ack_ff;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_ff) begin
            if (avs_address == `OFS_CTRL) begin
                avs_readdata <= {20'h0, ctrl_ff};
            end else if (avs_address == `OFS_BAUD) begin
                avs_readdata <= {16'h0, baud_ff};
            end else if (avs_address == `OFS_STATUS) begin
                avs_readdata <= {26'h0, tst_ff != ST_IDLE, rst_ff != ST_IDLE, muted_ff, cts_n, txfull_ff, rxfull_ff};
            end else if (avs_address == `OFS_RXDATA) begin
                avs_readdata <= {24'h0, rxbuf_ff};
            end else if (avs_address == `OFS_IRQ_STAT) begin
                avs_readdata <= {24'h0, irq_stat_ff};
            end else if (avs_address == `OFS_IRQ_EN) begin
                avs_readdata <= {24'h0, irq_en_ff};
            end else if (avs_address == `OFS_MATCH) begin
                avs_readdata <= {24'h0, match_ff};
            end else if (avs_address == `OFS_CLKSEL) begin
                avs_readdata <= {30'h0, clksel_ff};
            end else begin
                avs_readdata <= 32'h0;
            end
        end
    end

    wire wr_go = avs_write & ack_ff;
    wire rd_rx = avs_read & ack_ff & (avs_address == `OFS_RXDATA);

    always @(posedge clk) begin
        if (sys_rst) begin
            ctrl_ff <= 12'h0;
            baud_ff <= `BAUD_RST;
            match_ff <= 8'h0;
            clksel_ff <= `CLK_SLOW;
            irq_en_ff <= 8'h0;
        end else if (wr_go) begin
            if (hit(`OFS_CTRL)) ctrl_ff <= avs_writedata[11:0];
            if (hit(`OFS_BAUD)) baud_ff <= avs_writedata[15:0];
            if (hit(`OFS_MATCH)) match_ff <= avs_writedata[7:0];
            if (hit(`OFS_CLKSEL)) clksel_ff <= avs_writedata[1:0];
            if (hit(`OFS_IRQ_EN)) irq_en_ff <= avs_writedata[7:0];
        end
    end

    wire tx_load = txfull_ff && tst_ff == ST_IDLE && en && ctrl_ff[`CTRL_TXEN] &&
        !(ctrl_ff[`CTRL_CTSE] && cts_n) && ktick;
    wire tx_wr = (wr_go && hit(`OFS_TXDATA)) || dma_tx_ack;
    wire rx_ok = en && ctrl_ff[`CTRL_RXEN];  // works whether or not stop_mode is high
    wire start_det = rx_ok && rst_ff == ST_IDLE && ktick && rx_prev_ff && !rx_line;
    wire frame_end = rst_ff == ST_STOP && ktick && rcnt_ff == 16'h0;
    wire frame_good = frame_end && rx_line;
    wire deliver = frame_good && !muted_ff;
    wire is_match = rsh_ff[7] && rsh_ff[6:0] == match_ff[6:0];

    // transmitter, one bit per baud_ff + 1 kernel ticks
    always @(posedge clk) begin
        if (sys_rst) begin
            tst_ff <= ST_IDLE;
            tcnt_ff <= 16'h0;
            tbit_ff <= 3'h0;
            tsh_ff <= 8'h0;
            txd_ff <= 1'b1;
            txfull_ff <= 1'b0;
            txbuf_ff <= 8'h0;
        end else begin
            if (tx_wr) begin
                txbuf_ff <= dma_tx_ack ? avs_writedata[7:0] : avs_writedata[7:0];
            end
            if (tx_load) begin
                tsh_ff <= txbuf_ff;
                tst_ff <= ST_START;
                tcnt_ff <= baud_ff;
                txd_ff <= 1'b0;
            end else if (tst_ff != ST_IDLE && ktick) begin
                if (tcnt_ff != 16'h0) begin
                    tcnt_ff <= tcnt_ff - 16'h1;
                end else begin
                    tcnt_ff <= baud_ff;
                    case (tst_ff)
                        ST_START: begin
                            tst_ff <= ST_DATA;
                            tbit_ff <= 3'h0;
                            txd_ff <= tsh_ff[0];
                        end
                        ST_DATA: begin
                            if (tbit_ff == 3'h7) begin
                                tst_ff <= ST_STOP;
                                txd_ff <= 1'b1;
                            end else begin
                                tbit_ff <= tbit_ff + 3'h1;
                                txd_ff <= tsh_ff[tbit_ff + 3'h1];
                            end
                        end
                        default: tst_ff <= ST_IDLE;
                    endcase
                end
            end
            txfull_ff <= tx_wr | (txfull_ff & ~tx_load);
        end
    end

    assign tx_out = txd_ff;
    assign tx_oe_n = hdsel && tst_ff == ST_IDLE;  // line released while idle in half-duplex mode
    assign rts_n = ctrl_ff[`CTRL_RTSE] & rxfull_ff;
    assign dma_tx_req = ctrl_ff[`CTRL_DMAT] & ~txfull_ff & en;
    assign dma_rx_req = ctrl_ff[`CTRL_DMAR] & rxfull_ff;

    // receiver samples mid-bit: half count after start edge
    always @(posedge clk) begin
        if (sys_rst) begin
            rst_ff <= ST_IDLE;
            rcnt_ff <= 16'h0;
            rbit_ff <= 3'h0;
            rsh_ff <= 8'h0;
            rx_prev_ff <= 1'b1;
            rxbuf_ff <= 8'h0;
            rxfull_ff <= 1'b0;
            muted_ff <= 1'b0;
        end else begin
            if (ktick) rx_prev_ff <= rx_line;
            if (start_det) begin
                rst_ff <= ST_START;
                rcnt_ff <= {1'b0, baud_ff[15:1]};
            end else if (rst_ff != ST_IDLE && ktick) begin
                if (rcnt_ff != 16'h0) begin
                    rcnt_ff <= rcnt_ff - 16'h1;
                end else begin
                    rcnt_ff <= baud_ff;
                    case (rst_ff)
                        ST_START: begin
                            rst_ff <= rx_line ? ST_IDLE : ST_DATA;
                            rbit_ff <= 3'h0;
                        end
                        ST_DATA: begin
                            rsh_ff <= {rx_line, rsh_ff[7:1]};
                            if (rbit_ff == 3'h7) rst_ff <= ST_STOP;
                            rbit_ff <= rbit_ff + 3'h1;
                        end
                        default: rst_ff <= ST_IDLE;
                    endcase
                end
            end
            // address byte with top bit set un-mutes only on own address
            if (!ctrl_ff[`CTRL_MUTE]) begin
                muted_ff <= 1'b0;
            end else if (frame_good && rsh_ff[7]) begin
                muted_ff <= !is_match;
            end
            if (deliver && !(rxfull_ff && !rd_rx && !dma_rx_ack)) rxbuf_ff <= rsh_ff;
            rxfull_ff <= (deliver & ~rxfull_ff) | (rxfull_ff & ~rd_rx & ~dma_rx_ack) | (deliver & (rd_rx | dma_rx_ack));
        end
    end

    // wake event per selected source, allowed only while stop is flagged
    reg wake_ev;
    always @* begin
        case (wus)
            `WUS_START: wake_ev = start_det;
            `WUS_FRAME: wake_ev = frame_good;
            default: wake_ev = frame_good && rsh_ff == match_ff;
        endcase
    end
    wire wake_hit = wake_ev && stop_mode && ctrl_ff[`CTRL_STOP];
    assign wakeup = wake_hit;

    // sticky status: a set in the same cycle as a clear wins
    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_go && hit(`OFS_IRQ_CLR)) nxt_irq_stat = nxt_irq_stat & ~avs_writedata[7:0];
        if (deliver) nxt_irq_stat[`IRQ_RXNE] = 1'b1;
        if (tx_load) nxt_irq_stat[`IRQ_TXE] = 1'b1;
        if (tst_ff == ST_STOP && ktick && tcnt_ff == 16'h0) nxt_irq_stat[`IRQ_TC] = 1'b1;
        if (wake_hit) nxt_irq_stat[`IRQ_WAKE] = 1'b1;
        if (deliver && rxfull_ff && !rd_rx && !dma_rx_ack) nxt_irq_stat[`IRQ_ORE] = 1'b1;
        if (frame_end && !rx_line) nxt_irq_stat[`IRQ_FE] = 1'b1;
        if (ctrl_ff[`CTRL_CTSE] && cts_n && txfull_ff) nxt_irq_stat[`IRQ_CTSI] = 1'b1;
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            irq_stat_ff <= 8'h0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    assign irq = |(irq_stat_ff & irq_en_ff);
endmodule // low_power_serial_port

// ===== dv/lp_serial_port_assertions.sv
// pin-level assertions for the low-power serial port
`timescale 1ns/100ps
module lp_serial_chk (
    input wire clk,
    input wire sys_rst,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire tx_out,
    input wire tx_oe_n,
    input wire rts_n,
    input wire stop_mode,
    input wire dma_tx_req,
    input wire dma_rx_req,
    input wire dma_rx_ack,
    input wire wakeup,
    input wire irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_wait_one;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    property p_wait;
        $rose(avs_read || avs_write) |-> s_wait_one;
    endproperty
    a_wait: assert property (p_wait) else $error("waitrequest not exactly one cycle");
    property p_wreq;
        avs_waitrequest |-> (avs_read || avs_write);
    endproperty
    a_wreq: assert property (p_wreq) else $error("waitrequest without request");
    property p_rst;
        $fell(sys_rst) |-> tx_out && !tx_oe_n && !rts_n && !irq && !dma_tx_req && !dma_rx_req;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not at reset level");
    property p_hold;
        !avs_read |=> $stable(avs_readdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_wk1;
        wakeup |=> !wakeup;
    endproperty
    a_wk1: assert property (p_wk1) else $error("wakeup longer than one cycle");
    property p_wk2;
        wakeup |-> stop_mode;
    endproperty
    a_wk2: assert property (p_wk2) else $error("wakeup outside stop");
    property p_oe;
        !tx_out |-> !tx_oe_n;
    endproperty
    a_oe: assert property (p_oe) else $error("line low while not driven");
    property p_drx;
        dma_rx_ack |=> !dma_rx_req;
    endproperty
    a_drx: assert property (p_drx) else $error("rx request stays after ack");
endmodule // lp_serial_chk
bind low_power_serial_port lp_serial_chk u_chk (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_out(tx_out),
    .tx_oe_n(tx_oe_n), .rts_n(rts_n), .stop_mode(stop_mode), .dma_tx_req(dma_tx_req),
    .dma_rx_req(dma_rx_req), .dma_rx_ack(dma_rx_ack), .wakeup(wakeup), .irq(irq));

// ===== dv/far_uart.sv
// far-end 8n1 transceiver model on the serial line
`timescale 1ns/100ps
module far_uart #(parameter BIT = 8) (
    input wire clk,
    input wire line_in,
    output reg line_out,
    output reg cts_n
);
    reg [7:0] got = 8'h00;
    integer cnt = 0;
    integer j;
    initial begin
        line_out = 1'b1;
        cts_n = 1'b0;
    end
    task send(input [7:0] b);
        reg [9:0] f;
        integer i;
        begin
            f = {1'b1, b, 1'b0};
            for (i = 0; i < 10; i = i + 1) begin
                @(posedge clk) line_out <= f[i];
                repeat (BIT - 1) @(posedge clk);
            end
        end
    endtask
    // mid-bit sampling keeps the model tolerant of a tick of skew
    always begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge clk);
        for (j = 0; j < 8; j = j + 1) begin
            repeat (BIT) @(posedge clk);
            got[j] = line_in;
        end
        repeat (BIT) @(posedge clk);
        cnt = cnt + 1;
    end
endmodule // far_uart

// ===== dv/tb_top.sv
// testbench for the low-power serial port
`timescale 1ns/100ps
`include "lp_serial_regs.vh"
module tb_top;
    reg clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, stop_mode = 0, tk = 0, hd = 0, dtack = 0, drack = 0;
    reg woke = 0;
    reg [1:0] csel = 2'h0;
    reg [3:0] avs_address = 4'h0;
    reg [31:0] avs_writedata = 32'h0, q;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, osc_request, tx_out, tx_oe_n, rts_n, dma_tx_req, dma_rx_req, wakeup, irq, m_out, cts_n;
    wire rx_in = hd ? (m_out & (tx_oe_n | tx_out)) : m_out;
    integer miscompares = 0, comparisons = 0, cyc = 0, n = 0, k;
    // only the chosen kernel source ticks, so a wrong selector stalls the line and the byte check fails
    low_power_serial_port u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tick_slow_crystal_clock(tk & (csel == 2'h0)),
        .tick_internal_fast_rc_clock(tk & (csel == 2'h1)), .tick_system_clock(tk & (csel == 2'h2)),
        .tick_peripheral_bus_clock(tk & (csel == 2'h3)), .stop_mode(stop_mode), .osc_request(osc_request),
        .rx_in(rx_in), .tx_out(tx_out), .tx_oe_n(tx_oe_n), .cts_n(cts_n), .rts_n(rts_n), .dma_tx_req(dma_tx_req),
        .dma_rx_req(dma_rx_req), .dma_tx_ack(dtack), .dma_rx_ack(drack), .wakeup(wakeup), .irq(irq));
    far_uart #(.BIT(8)) u_far (.clk(clk), .line_in(tx_out), .line_out(m_out), .cts_n(cts_n));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tk <= ~tk;
        if (wakeup === 1'b1) woke <= 1'b1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    task final_report;
        begin
            if (miscompares == 0 && comparisons > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // one avalon cycle; returns mid-cycle so later checks see settled outputs
    task bus(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_read <= !w;
            avs_write <= w;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0) @(posedge clk);
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(negedge clk);
        end
    endtask
    task rc(input string nm, input [3:0] a, input [31:0] e);
        begin
            bus(0, a, 0);
            chk(nm, e, q);
        end
    endtask
    task wf(input [7:0] e);
        integer t;
        begin
            n = n + 1;
            t = 0;
            // look on the falling edge so the model's counter is never raced
            while (u_far.cnt < n && t < 400) begin
                @(negedge clk);
                t = t + 1;
            end
            chk("far byte", e, u_far.got);
        end
    endtask
    task snd(input [7:0] b);
        begin
            u_far.send(b);
            repeat (20) @(posedge clk);
            @(negedge clk);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rc("baud", `OFS_BAUD, `BAUD_RST);
        rc("unmapped", 4'hF, 0);
        rc("irq stat", `OFS_IRQ_STAT, 0);
        bus(1, `OFS_BAUD, 3);
        bus(1, `OFS_IRQ_EN, 32'h5);
        bus(1, `OFS_CTRL, 32'h7);
        for (k = 0; k < 4; k = k + 1) begin
            @(posedge clk) csel <= k[1:0];
            bus(1, `OFS_CLKSEL, k);
            chk("osc req", k == 1, osc_request);
            bus(1, `OFS_TXDATA, 8'hA0 + k[7:0]);
            wf(8'hA0 + k[7:0]);
        end
        // let the last stop bit finish so its completion flag is not set after the clear
        repeat (10) @(posedge clk);
        @(negedge clk) chk("irq tc", 1, irq);
        bus(1, `OFS_IRQ_CLR, 32'hFF);
        chk("irq clr", 0, irq);
        snd(8'h3C);
        rc("status", `OFS_STATUS, 32'h1);
        chk("irq rx", 1, irq);
        rc("rx data", `OFS_RXDATA, 8'h3C);
        bus(1, `OFS_CTRL, 32'h17);
        @(posedge clk) u_far.cts_n <= 1'b1;
        bus(1, `OFS_TXDATA, 8'h5A);
        repeat (200) @(posedge clk);
        chk("cts hold", n, u_far.cnt);
        u_far.cts_n <= 1'b0;
        wf(8'h5A);
        bus(1, `OFS_CTRL, 32'h27);
        snd(8'h11);
        chk("rts full", 1, rts_n);
        rc("rx data", `OFS_RXDATA, 8'h11);
        chk("rts free", 0, rts_n);
        bus(1, `OFS_CTRL, 32'hC07);
        chk("dma tx req", 1, dma_tx_req);
        @(posedge clk) avs_writedata <= 32'hC3;
        dtack <= 1'b1;
        @(posedge clk) dtack <= 1'b0;
        wf(8'hC3);
        snd(8'h96);
        chk("dma rx req", 1, dma_rx_req);
        @(posedge clk) drack <= 1'b1;
        @(posedge clk) drack <= 1'b0;
        @(negedge clk) chk("dma rx done", 0, dma_rx_req);
        bus(1, `OFS_MATCH, 8'h4E);
        @(posedge clk) stop_mode <= 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
            bus(1, `OFS_CTRL, 32'h87 | ((k > 2 ? 2 : k) << 8));
            @(posedge clk) woke <= 1'b0;
            snd(k == 2 ? 8'h21 : 8'h4E);
            chk("wake", k != 2, woke);
            bus(0, `OFS_RXDATA, 0);
        end
        @(posedge clk) stop_mode <= 1'b0;
        bus(1, `OFS_CTRL, 32'h47);
        snd(8'h85);
        bus(0, `OFS_RXDATA, 0);
        snd(8'h11);
        bus(0, `OFS_STATUS, 0);
        chk("muted drop", 32'h8, q & 32'h9);
        snd(8'hCE);
        bus(0, `OFS_STATUS, 0);
        chk("unmuted", 0, q[3]);
        bus(1, `OFS_CTRL, 32'hF);
        @(posedge clk) hd <= 1'b1;
        @(negedge clk) chk("oe idle", 1, tx_oe_n);
        bus(1, `OFS_TXDATA, 8'h69);
        wf(8'h69);
        repeat (8) @(posedge clk);
        bus(0, `OFS_STATUS, 0);
        chk("hd no echo", 0, q[0]);
        snd(8'h5C);
        rc("hd rx", `OFS_RXDATA, 8'h5C);
        final_report;
    end
endmodule // tb_top
